//--- shared/mode_regs_pkg.sv
// mode register map, field layout, reset values and command codes
// shared by the device end, the controller end and the link interface
package mode_regs_pkg;

  // mode register addresses
  localparam logic [5:0] ADDR_SET_POINT_CONTROL = 6'h0D;
  localparam logic [5:0] ADDR_DQ_REFERENCE      = 6'h0E;
  localparam logic [5:0] ADDR_SEGMENT_MASK      = 6'h11;
  localparam logic [5:0] ADDR_COUNT_LOW         = 6'h12;
  localparam logic [5:0] ADDR_COUNT_HIGH        = 6'h13;

  // field positions
  localparam int SPC_WRITE_SELECT_BIT = 6;
  localparam int SPC_OPERATING_BIT    = 7;
  localparam int DQREF_RANGE_BIT      = 6;
  localparam int DQREF_CODE_MSB       = 5;
  localparam int SEG_TOP_MSB          = 7;
  localparam int SEG_TOP_LSB          = 6;

  // reset values
  localparam logic [7:0]  SET_POINT_CONTROL_RESET = 8'h00;
  localparam logic [7:0]  DQ_REFERENCE_RESET      = 8'h00;
  localparam logic [7:0]  SEGMENT_MASK_RESET      = 8'h00;
  localparam logic [15:0] OSC_COUNT_RESET         = 16'h0000;
  localparam logic [15:0] OSC_COUNT_LIMIT         = 16'hFFFF;
  localparam logic [7:0]  READ_FILL               = 8'h00;

  // last defined reference code; codes above are reserved
  localparam logic [5:0] VREF_CODE_LAST = 6'h32;

  // link commands
  typedef enum logic [1:0] {
    CMD_NONE      = 2'h0,
    CMD_WRITE     = 2'h1,
    CMD_READ      = 2'h2,
    CMD_START_OSC = 2'h3
  } cmd_kind_e;

endpackage : mode_regs_pkg

//--- shared/mode_reg_link_if.sv
// mode register command link between the controller and the device
// assumes both ends run on the same clock; no clocking block
`timescale 1ns/1ps
interface mode_reg_link_if import mode_regs_pkg::*; ();
  logic       cmd_valid;
  cmd_kind_e  cmd_kind;
  logic       cmd_channel;
  logic [5:0] cmd_address;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic [7:0] rsp_data;

  modport device (
    input  cmd_valid,
    input  cmd_kind,
    input  cmd_channel,
    input  cmd_address,
    input  cmd_data,
    output rsp_valid,
    output rsp_data
  );

  modport controller (
    output cmd_valid,
    output cmd_kind,
    output cmd_channel,
    output cmd_address,
    output cmd_data,
    input  rsp_valid,
    input  rsp_data
  );
endinterface : mode_reg_link_if

//--- core/mode_reg_device.sv
// device end: reference setting, segment masks, oscillator count
// assumes one clock shared with the controller; oscillator tick and stop
// come from logic on the same clock
// tick is one pulse per oscillator event, stop may be a pulse or a level
`timescale 1ns/1ps

// Functional notes
// - six-bit code, 15.0% low, above 110010B reserved
// - bit 6 picks range, high 32.9..62.9%
// - one reference copy per frequency set point
// - segment mask write-only, 1 disables refresh
// - mask bit n governs segment of row top bits
// - each channel keeps own segment mask
// - controller zeroes top mask bits on odd densities
// - low count register returns count bits 7:0
// - high count register returns count bits 15:8
// - controller reads both counts and concatenates
// - start oscillator command clears both counts
// - controller may retune strobe phase from count
// - decode mask 11H, low 12H, high 13H
// - access only write-selected set point copy
// - operate from operating set point copy
module mode_reg_device
  import mode_regs_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // link to controller
  mode_reg_link_if.device  link,
  // oscillator measurement
  input  wire logic        i_osc_tick,
  input  wire logic        i_osc_stop,
  output logic             o_osc_running,
  // refresh segment query
  input  wire logic        i_refresh_channel,
  input  wire logic [2:0]  i_refresh_row_top,
  output logic             o_refresh_allowed,
  // active settings
  output logic [5:0]       o_vref_code,
  output logic             o_vref_range,
  output logic             o_vref_reserved,
  output logic [15:0]      o_segment_masks
);

  typedef struct packed {
    // bit 6 write select, bit 7 operating select
    logic [7:0]      set_point_control;
    // one reference copy per frequency set point
    logic [1:0][7:0] dq_reference;
    // one segment mask per channel, indexed by channel
    logic [1:0][7:0] segment_mask;
    // oscillator measurement
    logic [15:0]     osc_count;
    logic            osc_running;
    // read answer towards the controller
    logic            rsp_valid;
    logic [7:0]      rsp_data;
    // registered copies of the live settings
    logic            refresh_allowed;
    logic [5:0]      vref_code;
    logic            vref_range;
    logic            vref_reserved;
  } device_state_s;

  // refresh allowed everywhere until a mask is written
  localparam device_state_s STATE_RESET = '{
    set_point_control: SET_POINT_CONTROL_RESET,
    dq_reference:      {DQ_REFERENCE_RESET, DQ_REFERENCE_RESET},
    segment_mask:      {SEGMENT_MASK_RESET, SEGMENT_MASK_RESET},
    osc_count:         OSC_COUNT_RESET,
    osc_running:       1'b0,
    rsp_valid:         1'b0,
    rsp_data:          READ_FILL,
    refresh_allowed:   1'b1,
    vref_code:         DQ_REFERENCE_RESET[DQREF_CODE_MSB:0],
    vref_range:        DQ_REFERENCE_RESET[DQREF_RANGE_BIT],
    vref_reserved:     1'b0
  };

  device_state_s state;
  device_state_s next_state;

  logic       write_select;
  logic       operating_select;
  logic       start_cmd;
  logic       stop_now;
  logic       count_enable;
  logic       count_at_limit;
  logic [7:0] active_reference;
  logic [5:0] active_code;
  logic [7:0] query_mask;
  logic       query_bit;

  always_comb begin
    next_state = state;
    next_state.rsp_valid = 1'b0;
    // selects come from the stored control register, so a write to it
    // steers the commands that follow it, not itself
    write_select = state.set_point_control[SPC_WRITE_SELECT_BIT];
    operating_select = state.set_point_control[SPC_OPERATING_BIT];
    start_cmd = link.cmd_valid && (link.cmd_kind == CMD_START_OSC);

    if (link.cmd_valid) begin
      unique case (link.cmd_kind)
        CMD_WRITE: begin
          unique case (link.cmd_address)
            ADDR_SET_POINT_CONTROL: begin
              next_state.set_point_control = link.cmd_data;
            end
            ADDR_DQ_REFERENCE: begin
              // reserved codes are simply stored
              next_state.dq_reference[write_select] =
                link.cmd_data;
            end
            ADDR_SEGMENT_MASK: begin
              next_state.segment_mask[link.cmd_channel] =
                link.cmd_data;
            end
            // count registers are read-only; other addresses ignored
            default: begin
            end
          endcase
        end
        CMD_READ: begin
          next_state.rsp_valid = 1'b1;
          unique case (link.cmd_address)
            ADDR_SET_POINT_CONTROL: begin
              next_state.rsp_data = state.set_point_control;
            end
            ADDR_DQ_REFERENCE: begin
              next_state.rsp_data =
                state.dq_reference[write_select];
            end
            ADDR_COUNT_LOW: begin
              next_state.rsp_data = state.osc_count[7:0];
            end
            ADDR_COUNT_HIGH: begin
              next_state.rsp_data = state.osc_count[15:8];
            end
            // write-only mask and unmapped addresses read as fill
            default: begin
              next_state.rsp_data = READ_FILL;
            end
          endcase
        end
        CMD_START_OSC: begin
          // a restart also drops a count left from an earlier run
          next_state.osc_count = OSC_COUNT_RESET;
          next_state.osc_running = 1'b1;
        end
        CMD_NONE: begin
          // idle cycle on the link
        end
      endcase
    end

    // stop has priority over a tick arriving in the same cycle
    stop_now = state.osc_running && !start_cmd && i_osc_stop;
    // a tick in the start cycle is dropped so the new count starts at zero
    count_enable = state.osc_running && !start_cmd && !i_osc_stop
                   && i_osc_tick;
    // saturate rather than wrap so a long run never reads small
    count_at_limit = (state.osc_count == OSC_COUNT_LIMIT);
    if (stop_now) begin
      next_state.osc_running = 1'b0;
    end
    if (count_enable && !count_at_limit) begin
      next_state.osc_count = 16'(state.osc_count + 16'h0001);
    end

    // active settings follow the operating set point copy
    active_reference = next_state.dq_reference[operating_select];
    active_code = active_reference[DQREF_CODE_MSB:0];
    next_state.vref_code = active_code;
    next_state.vref_range = active_reference[DQREF_RANGE_BIT];
    // reserved codes are flagged and stored, never clipped
    next_state.vref_reserved = (active_code > VREF_CODE_LAST);

    query_mask = state.segment_mask[i_refresh_channel];
    query_bit = query_mask[i_refresh_row_top];
    // a set mask bit turns refresh off for that segment
    next_state.refresh_allowed = !query_bit;
  end

  // every field has a constant reset value, read data included
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // answer towards the controller
  assign link.rsp_valid    = state.rsp_valid;
  assign link.rsp_data     = state.rsp_data;

  // live settings and measurement state
  assign o_osc_running     = state.osc_running;
  assign o_refresh_allowed = state.refresh_allowed;
  assign o_vref_code       = state.vref_code;
  assign o_vref_range      = state.vref_range;
  assign o_vref_reserved   = state.vref_reserved;
  assign o_segment_masks   = state.segment_mask;

endmodule : mode_reg_device

//--- core/mode_reg_controller.sv
// controller end: issues mode register writes, reads and oscillator starts
// assumes the device answers every read exactly one cycle after taking it
`timescale 1ns/1ps
module mode_reg_controller
  import mode_regs_pkg::*;
#(
  parameter bit TOP_SEGMENTS_PRESENT = 1'b1
)
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // link to device
  mode_reg_link_if.controller link,
  // single register request
  input  wire logic        i_req_valid,
  input  cmd_kind_e        i_req_kind,
  input  wire logic        i_req_channel,
  input  wire logic [5:0]  i_req_address,
  input  wire logic [7:0]  i_req_data,
  output logic             o_req_ready,
  output logic             o_req_refused,
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_data,
  // oscillator count fetch
  input  wire logic        i_count_fetch,
  output logic             o_count_valid,
  output logic [15:0]      o_count
);

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0001,
    ST_WAIT_READ = 4'b0010,
    ST_WAIT_LOW  = 4'b0100,
    ST_WAIT_HIGH = 4'b1000
  } ctrl_state_e;

  typedef struct packed {
    ctrl_state_e fsm;
    logic        cmd_valid;
    cmd_kind_e   cmd_kind;
    logic        cmd_channel;
    logic [5:0]  cmd_address;
    logic [7:0]  cmd_data;
    logic        refused;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        count_valid;
    logic [15:0] count;
  } ctrl_state_s;

  localparam ctrl_state_s STATE_RESET = '{
    fsm: ST_IDLE, cmd_valid: 1'b0, cmd_kind: CMD_NONE, cmd_channel: 1'b0,
    cmd_address: 6'h00, cmd_data: 8'h00, refused: 1'b0, rsp_valid: 1'b0,
    rsp_data: 8'h00, count_valid: 1'b0, count: OSC_COUNT_RESET
  };

  ctrl_state_s state;
  ctrl_state_s next_state;

  always_comb begin
    next_state = state;
    next_state.cmd_valid = 1'b0;
    next_state.cmd_kind = CMD_NONE;
    next_state.refused = 1'b0;
    next_state.rsp_valid = 1'b0;
    next_state.count_valid = 1'b0;
    unique case (state.fsm)
      ST_IDLE: begin
        if (i_req_valid && i_req_kind != CMD_NONE) begin
          next_state.cmd_channel = i_req_channel;
          next_state.cmd_address = i_req_address;
          next_state.cmd_data = i_req_data;
          if (i_req_kind == CMD_WRITE && i_req_address == ADDR_DQ_REFERENCE
              && i_req_data[DQREF_CODE_MSB:0] > VREF_CODE_LAST) begin
            next_state.refused = 1'b1;
          end else begin
            next_state.cmd_valid = 1'b1;
            next_state.cmd_kind = i_req_kind;
            if (i_req_kind == CMD_WRITE && !TOP_SEGMENTS_PRESENT
                && i_req_address == ADDR_SEGMENT_MASK) begin
              next_state.cmd_data[SEG_TOP_MSB:SEG_TOP_LSB] = 2'b00;
            end
            if (i_req_kind == CMD_READ) begin
              next_state.fsm = ST_WAIT_READ;
            end
          end
        end else if (i_count_fetch) begin
          next_state.cmd_valid = 1'b1;
          next_state.cmd_kind = CMD_READ;
          next_state.cmd_address = ADDR_COUNT_LOW;
          next_state.fsm = ST_WAIT_LOW;
        end
      end
      ST_WAIT_READ: begin
        if (link.rsp_valid) begin
          next_state.rsp_valid = 1'b1;
          next_state.rsp_data = link.rsp_data;
          next_state.fsm = ST_IDLE;
        end
      end
      ST_WAIT_LOW: begin
        if (link.rsp_valid) begin
          next_state.count[7:0] = link.rsp_data;
          next_state.cmd_valid = 1'b1;
          next_state.cmd_kind = CMD_READ;
          next_state.cmd_address = ADDR_COUNT_HIGH;
          next_state.fsm = ST_WAIT_HIGH;
        end
      end
      ST_WAIT_HIGH: begin
        if (link.rsp_valid) begin
          // count feeds strobe phase retuning upstream
          next_state.count[15:8] = link.rsp_data;
          next_state.count_valid = 1'b1;
          next_state.fsm = ST_IDLE;
        end
      end
      default: begin
        next_state = STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign link.cmd_valid   = state.cmd_valid;
  assign link.cmd_kind    = state.cmd_kind;
  assign link.cmd_channel = state.cmd_channel;
  assign link.cmd_address = state.cmd_address;
  assign link.cmd_data    = state.cmd_data;
  assign o_req_ready      = (state.fsm == ST_IDLE);
  assign o_req_refused    = state.refused;
  assign o_rsp_valid      = state.rsp_valid;
  assign o_rsp_data       = state.rsp_data;
  assign o_count_valid    = state.count_valid;
  assign o_count          = state.count;

endmodule : mode_reg_controller

//--- test/mode_reg_link_props.sv
// checker for the mode register link between controller and device
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module mode_reg_link_props
  import mode_regs_pkg::*;
#(
  parameter bit TOP_SEGMENTS_PRESENT = 1'b1
)
(
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_reset,
  // link signals
  input wire logic       cmd_valid,
  input cmd_kind_e       cmd_kind,
  input wire logic       cmd_channel,
  input wire logic [5:0] cmd_address,
  input wire logic [7:0] cmd_data,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  logic rd_cmd;
  logic wr_cmd;
  assign rd_cmd = cmd_valid && cmd_kind == CMD_READ;
  assign wr_cmd = cmd_valid && cmd_kind == CMD_WRITE;

  a_read_answer: assert property (rd_cmd |=> rsp_valid)
    else $error("read not answered next cycle");
  a_no_stray_answer: assert property (!rd_cmd |=> !rsp_valid)
    else $error("answer without a read");
  a_mask_read_fill: assert property (rd_cmd &&
    cmd_address == ADDR_SEGMENT_MASK |=> rsp_data == READ_FILL)
    else $error("write-only mask read back");
  a_start_clears_count: assert property (
    (cmd_valid && cmd_kind == CMD_START_OSC) ##1
    (rd_cmd && cmd_address == ADDR_COUNT_LOW) |=> (rsp_data <= 8'h01))
    else $error("count not cleared by start");
  a_no_reserved_code: assert property (wr_cmd &&
    cmd_address == ADDR_DQ_REFERENCE |->
    cmd_data[DQREF_CODE_MSB:0] <= VREF_CODE_LAST)
    else $error("reserved reference code sent");
  a_read_gap_kept: assert property (rd_cmd |=> !cmd_valid)
    else $error("command during read answer");
  a_kind_present: assert property (cmd_valid |-> cmd_kind != CMD_NONE)
    else $error("valid command without kind");
  a_top_bits_zero: assert property (wr_cmd &&
    cmd_address == ADDR_SEGMENT_MASK && !TOP_SEGMENTS_PRESENT |->
    cmd_data[SEG_TOP_MSB:SEG_TOP_LSB] == 2'h0)
    else $error("absent top segments written");
  a_rsp_data_held: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("read data moved without answer");
endmodule : mode_reg_link_props

//--- test/tb.sv
// bench: controller and device joined by the link, user sides driven here
// assumes 250 MHz clock; inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module tb;
  import mode_regs_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_req_valid = 1'b0;
  cmd_kind_e   i_req_kind = CMD_NONE;
  logic        i_req_channel = 1'b0;
  logic [5:0]  i_req_address = 6'h00;
  logic [7:0]  i_req_data = 8'h00;
  logic        i_count_fetch = 1'b0;
  logic        i_osc_tick = 1'b0;
  logic        i_osc_stop = 1'b0;
  logic        i_refresh_channel = 1'b0;
  logic [2:0]  i_refresh_row_top = 3'h0;
  logic        o_req_ready, o_req_refused, o_rsp_valid, o_count_valid;
  logic        o_osc_running, o_refresh_allowed, o_vref_range;
  logic        o_vref_reserved;
  logic [7:0]  o_rsp_data;
  logic [15:0] o_count, o_segment_masks;
  logic [5:0]  o_vref_code;
  int unsigned err_count = 0;
  int unsigned samples_checked = 0;
  int unsigned cycles = 0;
  logic [31:0] seed = 32'h0000AC35;

  always #2 i_clock = ~i_clock;

  mode_reg_link_if link ();
  // top segments absent, so the controller must clear mask bits 7:6
  mode_reg_controller #(.TOP_SEGMENTS_PRESENT(1'b0)) i_mode_reg_controller (
    .i_clock, .i_reset, .link, .i_req_valid, .i_req_kind, .i_req_channel,
    .i_req_address, .i_req_data, .o_req_ready, .o_req_refused,
    .o_rsp_valid, .o_rsp_data, .i_count_fetch, .o_count_valid, .o_count);
  mode_reg_device i_mode_reg_device (
    .i_clock, .i_reset, .link, .i_osc_tick, .i_osc_stop, .o_osc_running,
    .i_refresh_channel, .i_refresh_row_top, .o_refresh_allowed,
    .o_vref_code, .o_vref_range, .o_vref_reserved, .o_segment_masks);
  mode_reg_link_props #(.TOP_SEGMENTS_PRESENT(1'b0)) i_mode_reg_link_props (
    .i_clock, .i_reset, .cmd_valid(link.cmd_valid),
    .cmd_kind(link.cmd_kind), .cmd_channel(link.cmd_channel),
    .cmd_address(link.cmd_address), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick

  task automatic wait_ready();
    for (int n = 0; n < 20 && o_req_ready !== 1'b1; n++) tick(1);
  endtask : wait_ready

  task automatic req(input cmd_kind_e k, input logic [5:0] a,
                     input logic [7:0] d, input logic ch = 1'b0);
    wait_ready();
    i_req_valid = 1'b1;
    i_req_kind = k;
    i_req_address = a;
    i_req_data = d;
    i_req_channel = ch;
    tick(1);
    i_req_valid = 1'b0;
  endtask : req

  task automatic rd(input logic [5:0] a, input logic ch,
                    output logic [7:0] q);
    req(CMD_READ, a, 8'h00, ch);
    chk("busy on read", o_req_ready, 1'b0);
    for (int n = 0; n < 8 && o_rsp_valid !== 1'b1; n++) tick(1);
    chk("read answered", o_rsp_valid, 1'b1);
    q = o_rsp_data;
  endtask : rd

  task automatic fetch(output logic [15:0] q);
    wait_ready();
    i_count_fetch = 1'b1;
    tick(1);
    i_count_fetch = 1'b0;
    for (int n = 0; n < 12 && o_count_valid !== 1'b1; n++) tick(1);
    chk("count fetched", o_count_valid, 1'b1);
    q = o_count;
  endtask : fetch

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // run limit: the sequence needs under a thousand cycles
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    logic [31:0] r;
    logic [6:0]  v;
    logic [6:0]  cp [2];
    logic        t;
    logic [7:0]  q;
    logic [15:0] c;
    logic [15:0] mk;
    int          n;
    cp[0] = 7'h00;
    cp[1] = 7'h00;
    mk = 16'h0000;
    tick(10);
    i_reset = 1'b0;
    chk("vref reset", {o_vref_range, o_vref_code}, 16'h0000);
    chk("mask reset", o_segment_masks, mk);
    // each pass writes the idle copy, then makes it the live one
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      v = {r[6], (i == 0) ? VREF_CODE_LAST : 6'(r % 51)};
      t = i[0];
      req(CMD_WRITE, ADDR_SET_POINT_CONTROL, {~t, t, 6'h00});
      req(CMD_WRITE, ADDR_DQ_REFERENCE, {1'b0, v});
      rd(ADDR_DQ_REFERENCE, 1'b0, q);
      chk("vref read", q, {1'b0, v});
      chk("vref idle", {o_vref_range, o_vref_code}, cp[~t]);
      cp[t] = v;
      req(CMD_WRITE, ADDR_SET_POINT_CONTROL, {t, t, 6'h00});
      rd(ADDR_SET_POINT_CONTROL, 1'b0, q);
      tick(1);
      chk("vref live", {o_vref_range, o_vref_code}, v);
      chk("vref reserved", o_vref_reserved, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      req(CMD_WRITE, ADDR_DQ_REFERENCE, i ? 8'h7F : 8'h33);
      chk("refused", o_req_refused, 1'b1);
    end
    rd(ADDR_DQ_REFERENCE, 1'b0, q);
    chk("vref kept", q, {1'b0, cp[1]});
    for (int ch = 0; ch < 2; ch++) begin
      r = rnd();
      req(CMD_WRITE, ADDR_SEGMENT_MASK, r[7:0], ch[0]);
      rd(ADDR_SEGMENT_MASK, ch[0], q);
      chk("mask read", q, READ_FILL);
      mk[ch*8 +: 8] = {2'h0, r[5:0]};
      chk("masks", o_segment_masks, mk);
      for (int j = 0; j < 8; j++) begin
        i_refresh_channel = ch[0];
        i_refresh_row_top = j[2:0];
        tick(1);
        chk("allowed", o_refresh_allowed, !mk[ch*8+j]);
      end
    end
    req(CMD_WRITE, ADDR_COUNT_LOW, 8'hA5);
    rd(ADDR_COUNT_LOW, 1'b0, q);
    chk("count ro", q, 8'h00);
    rd(6'h3F, 1'b0, q);
    chk("unmapped", q, READ_FILL);
    // fetch held over the start so the low read follows it directly
    i_count_fetch = 1'b1;
    req(CMD_START_OSC, 6'h00, 8'h00);
    fetch(c);
    chk("count fresh", c, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      n = k ? 256 : 200 + int'(rnd() % 400);
      req(CMD_START_OSC, 6'h00, 8'h00);
      tick(1);
      chk("running", o_osc_running, 1'b1);
      i_osc_tick = 1'b1;
      tick(n);
      i_osc_tick = 1'b0;
      i_osc_stop = 1'b1;
      tick(1);
      i_osc_stop = 1'b0;
      chk("stopped", o_osc_running, 1'b0);
      fetch(c);
      chk("count", c, n[15:0]);
      rd(ADDR_COUNT_LOW, 1'b0, q);
      chk("count low", q, n[7:0]);
      rd(ADDR_COUNT_HIGH, 1'b0, q);
      chk("count high", q, n[15:8]);
    end
    summarize();
  end
endmodule : tb
